// *** rtl/tic_pkg.sv ***
// Purpose: Shared constants and types for the time interval counter
// Assumes: Special function register bus with 8-bit address and data
// Notes:   Offsets are byte addresses on that bus
package tic_pkg;
   // Register addresses
   localparam logic [7:0] TIC_ADDR_CTL      = 8'ha1;
   localparam logic [7:0] TIC_ADDR_FRAC     = 8'ha2;
   localparam logic [7:0] TIC_ADDR_SEC      = 8'ha3;
   localparam logic [7:0] TIC_ADDR_MIN      = 8'ha4;
   localparam logic [7:0] TIC_ADDR_HOUR     = 8'ha5;
   localparam logic [7:0] TIC_ADDR_INTERVAL_COMPARE_VALUE   = 8'ha6;
   // Control field positions
   localparam int TIC_BIT_HOUR24 = 6;
   localparam int TIC_BIT_TB_HI  = 5;
   localparam int TIC_BIT_TB_LO  = 4;
   localparam int TIC_BIT_SINGLE = 3;
   localparam int TIC_BIT_FLAG   = 2;
   localparam int TIC_BIT_IEN    = 1;
   localparam int TIC_BIT_CEN    = 0;
   // Reset values
   localparam logic [7:0] TIC_RST_CTL       = 8'h00;
   localparam logic [7:0] TIC_RST_INTERVAL_COMPARE_VALUE    = 8'h00;
   localparam logic [7:0] TIC_RST_TIME      = 8'h00;
   // Counter limits
   localparam logic [7:0] TIC_FRAC_MAX      = 8'h7f;
   localparam logic [7:0] TIC_SEC_MAX       = 8'h3b;
   localparam logic [7:0] TIC_MIN_MAX       = 8'h3b;
   localparam logic [7:0] TIC_HOUR24_MAX    = 8'h17;
   localparam logic [7:0] TIC_HOUR255_MAX   = 8'hff;
   // Timing: crystal edges per 1/128 second
   localparam int TIC_XTAL_HZ    = 32768;
   localparam int TIC_FRAC_HZ    = 128;
   localparam int TIC_PRESCALE   = TIC_XTAL_HZ / TIC_FRAC_HZ;
   localparam logic [7:0] TIC_PRESCALE_MAX = 8'(TIC_PRESCALE - 1);
   localparam logic [15:0] TIC_VECTOR      = 16'h0053;
   localparam logic [15:0] TIC_NO_VECTOR   = 16'h0000;

   // Timebase choices
   typedef enum logic [1:0] {
      TIC_TB_FRAC = 2'h0,
      TIC_TB_SEC  = 2'h1,
      TIC_TB_MIN  = 2'h2,
      TIC_TB_HOUR = 2'h3
   } tic_tb_type;

   // Control register fields
   typedef struct packed {
      logic       hour_range_24;
      tic_tb_type timebase;
      logic       single_shot;
      logic       interval_match_flag;
      logic       interval_count_enable;
      logic       time_clock_enable;
   } tic_ctl_type;

   // Time of day registers
   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] frac;
   } tic_time_type;
endpackage

// *** rtl/tic_edge_sync.sv ***
// Purpose: Bring the crystal clock into the core domain as a tick
// Assumes: Crystal runs far slower than the core clock
// Notes:   One pulse per rising crystal edge, three cycles late
`timescale 1ns/10ps
module tic_edge_sync (
   input  wire logic clock_in,   // Core clock
   input  wire logic srst_in,    // Synchronous reset
   input  wire logic async_in,   // Foreign level
   output logic      rise_out    // One-cycle pulse on rise
);
   logic meta_q, sync_q, last_q, rise_q;
   logic rise_d;

   // First flop feeds only the second one
   always_comb begin
      rise_d = sync_q & ~last_q;
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
         rise_q <= rise_d;
      end
   end

   assign rise_out = rise_q;
endmodule // tic_edge_sync

// *** rtl/tic_interval_timer_unit.sv ***
// Purpose: Time interval counter with time of day chain
// Assumes: Crystal level sampled on the core clock, which must keep running
// Notes:   Register port is a plain special function register port
// Functional notes
// - Counting follows the 32.768 kHz crystal, also while powered down.
// - Control bits 5:4 choose which time overflow clocks the interval counter.
// - Counter equal to compare value sets flag bit 2; only software clears it.
// - Enabled flag in power-down wakes the core, vector 0053H.
// - Control bit 6 selects hours 0..23, else 0..255.
// - Single-shot bit 3 clears interval enable on timeout, else reload.
// - Control bit 1 enables the interval counter.
// - Bit 0 gates time clock; clearing restores last written time values.
// - Time registers are writable while time clock enable is low.
// - Control bit 7 is absent; writes ignored, reads zero.
// - Intervals span one 1/128 s tick to 256 hours (compare value 0).
// - Compare register holds an 8-bit target, 0 to 255.
// - Fraction count advances each 1/128 s, 0..127, then carries seconds.
// - Seconds and minutes count 0..59, carrying to the next register.
`timescale 1ns/10ps
module tic_interval_timer_unit
   import tic_pkg::*;
(
   input  wire logic        clock_in,        // Core clock, 10 MHz
   input  wire logic        srst_in,         // Synchronous reset
   input  wire logic        xtal_in,         // 32.768 kHz crystal level
   input  wire logic [7:0]  sfr_addr_in,     // Register address
   input  wire logic [7:0]  sfr_wdata_in,    // Write data
   input  wire logic        sfr_wr_in,       // Write strobe
   input  wire logic        sfr_rd_in,       // Read strobe
   input  wire logic        irq_enable_in,   // Core enable for this interrupt
   input  wire logic        power_down_in,   // Core is powered down
   output logic [7:0]       sfr_rdata_out,   // Read data, held
   output logic             irq_out,         // Interrupt request level
   output logic             wake_out,        // Wake from power-down
   output logic [15:0]      vector_out       // Service address while requested
);
   logic xtal_rise;

   // Crystal edges become core-domain ticks
   tic_edge_sync u_sync (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .async_in (xtal_in),
      .rise_out (xtal_rise)
   );

   tic_ctl_type  ctl_q, ctl_d;
   tic_time_type time_q, time_d, shadow_q, shadow_d;
   logic [7:0]   interval_compare_value_q, interval_compare_value_d;
   logic [7:0]   icount_q, icount_d;
   logic [7:0]   presc_q, presc_d;
   logic [7:0]   rdata_q, rdata_d;
   logic         irq_q, irq_d, wake_q, wake_d;
   logic [15:0]  vector_q, vector_d;

   logic         wr_ctl, wr_time, wr_int;
   logic         frac_tick, of_frac, of_sec, of_min, of_hour;
   logic         tb_tick, match;
   logic [7:0]   hour_max, icount_inc;

   // Decode strobes
   always_comb begin
      wr_ctl  = sfr_wr_in && (sfr_addr_in == TIC_ADDR_CTL);
      wr_int  = sfr_wr_in && (sfr_addr_in == TIC_ADDR_INTERVAL_COMPARE_VALUE);
      wr_time = sfr_wr_in && !ctl_q.time_clock_enable &&
                (sfr_addr_in >= TIC_ADDR_FRAC) && (sfr_addr_in <= TIC_ADDR_HOUR);
   end

   // Time chain carries; every stage gated by the time clock enable
   always_comb begin
      hour_max  = ctl_q.hour_range_24 ? TIC_HOUR24_MAX : TIC_HOUR255_MAX;
      frac_tick = ctl_q.time_clock_enable && xtal_rise && (presc_q == TIC_PRESCALE_MAX);
      of_frac   = frac_tick && (time_q.frac >= TIC_FRAC_MAX);
      of_sec    = of_frac && (time_q.sec >= TIC_SEC_MAX);
      of_min    = of_sec && (time_q.min >= TIC_MIN_MAX);
      of_hour   = of_min && (time_q.hour >= hour_max);
      unique case (ctl_q.timebase)
         TIC_TB_FRAC: tb_tick = frac_tick;
         TIC_TB_SEC:  tb_tick = of_frac;
         TIC_TB_MIN:  tb_tick = of_sec;
         TIC_TB_HOUR: tb_tick = of_min;
      endcase
      icount_inc = icount_q + 8'h01;
      match      = ctl_q.interval_count_enable && tb_tick && (icount_inc == interval_compare_value_q);
   end

   // Next time, shadow and prescaler values
   always_comb begin
      time_d   = time_q;
      shadow_d = shadow_q;
      presc_d  = presc_q;
      if (!ctl_q.time_clock_enable) begin
         presc_d = 8'h00;
         time_d  = shadow_q;
         if (wr_time) begin
            unique case (sfr_addr_in)
               TIC_ADDR_FRAC: begin
                  shadow_d.frac = sfr_wdata_in;
                  time_d.frac   = sfr_wdata_in;
               end
               TIC_ADDR_SEC: begin
                  shadow_d.sec = sfr_wdata_in;
                  time_d.sec   = sfr_wdata_in;
               end
               TIC_ADDR_MIN: begin
                  shadow_d.min = sfr_wdata_in;
                  time_d.min   = sfr_wdata_in;
               end
               default: begin
                  shadow_d.hour = sfr_wdata_in;
                  time_d.hour   = sfr_wdata_in;
               end
            endcase
         end
      end else if (xtal_rise) begin
         // Prescaler wraps itself at 256 crystal edges
         presc_d = presc_q + 8'h01;
         if (frac_tick) begin
            time_d.frac = of_frac ? 8'h00 : time_q.frac + 8'h01;
            if (of_frac) begin
               time_d.sec = of_sec ? 8'h00 : time_q.sec + 8'h01;
            end
            if (of_sec) begin
               time_d.min = of_min ? 8'h00 : time_q.min + 8'h01;
            end
            if (of_min) begin
               time_d.hour = of_hour ? 8'h00 : time_q.hour + 8'h01;
            end
         end
      end
   end

   // Control, compare and interval counter
   always_comb begin
      ctl_d    = ctl_q;
      interval_compare_value_d = wr_int ? sfr_wdata_in : interval_compare_value_q;
      icount_d = icount_q;
      if (wr_ctl) begin
         // Bit 7 simply has no storage
         ctl_d.hour_range_24         = sfr_wdata_in[TIC_BIT_HOUR24];
         ctl_d.timebase              = tic_tb_type'(sfr_wdata_in[TIC_BIT_TB_HI:TIC_BIT_TB_LO]);
         ctl_d.single_shot           = sfr_wdata_in[TIC_BIT_SINGLE];
         ctl_d.interval_count_enable = sfr_wdata_in[TIC_BIT_IEN];
         ctl_d.time_clock_enable     = sfr_wdata_in[TIC_BIT_CEN];
      end else if (match && ctl_q.single_shot) begin
         ctl_d.interval_count_enable = 1'b0;
      end
      // Writing zero clears the flag, a match in the same cycle still sets it
      ctl_d.interval_match_flag = match ||
         (ctl_q.interval_match_flag && !(wr_ctl && !sfr_wdata_in[TIC_BIT_FLAG]));
      if (!ctl_q.interval_count_enable) begin
         icount_d = 8'h00;
      end else if (match) begin
         icount_d = 8'h00;
      end else if (tb_tick) begin
         icount_d = icount_inc;
      end
   end

   // Read data and interrupt outputs
   always_comb begin
      rdata_d = rdata_q;
      if (sfr_rd_in) begin
         unique case (sfr_addr_in)
            TIC_ADDR_CTL:    rdata_d = {1'b0, ctl_q};
            TIC_ADDR_FRAC:   rdata_d = time_q.frac;
            TIC_ADDR_SEC:    rdata_d = time_q.sec;
            TIC_ADDR_MIN:    rdata_d = time_q.min;
            TIC_ADDR_HOUR:   rdata_d = time_q.hour;
            TIC_ADDR_INTERVAL_COMPARE_VALUE: rdata_d = interval_compare_value_q;
            default:         rdata_d = 8'h00;
         endcase
      end
      irq_d    = ctl_q.interval_match_flag && irq_enable_in;
      wake_d   = irq_d && power_down_in;
      vector_d = irq_d ? TIC_VECTOR : TIC_NO_VECTOR;
   end

   // Register everything
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctl_q    <= tic_ctl_type'(TIC_RST_CTL[6:0]);
         time_q   <= {4{TIC_RST_TIME}};
         shadow_q <= {4{TIC_RST_TIME}};
         interval_compare_value_q <= TIC_RST_INTERVAL_COMPARE_VALUE;
         icount_q <= 8'h00;
         presc_q  <= 8'h00;
         rdata_q  <= 8'h00;
         irq_q    <= 1'b0;
         wake_q   <= 1'b0;
         vector_q <= TIC_NO_VECTOR;
      end else begin
         ctl_q    <= ctl_d;
         time_q   <= time_d;
         shadow_q <= shadow_d;
         interval_compare_value_q <= interval_compare_value_d;
         icount_q <= icount_d;
         presc_q  <= presc_d;
         rdata_q  <= rdata_d;
         irq_q    <= irq_d;
         wake_q   <= wake_d;
         vector_q <= vector_d;
      end
   end

   assign sfr_rdata_out = rdata_q;
   assign irq_out       = irq_q;
   assign wake_out      = wake_q;
   assign vector_out    = vector_q;
endmodule // tic_interval_timer_unit

// *** bench/tic_properties.sv ***
// Purpose: Port-level checks for the interval timer unit
// Assumes: One clock domain, synchronous reset
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module tic_properties
   import tic_pkg::*;
(
   input wire logic        clock_in,       // Core clock
   input wire logic        srst_in,        // Reset
   input wire logic        xtal_in,        // Crystal level
   input wire logic [7:0]  sfr_addr_in,    // Address
   input wire logic [7:0]  sfr_wdata_in,   // Write data
   input wire logic        sfr_wr_in,      // Write strobe
   input wire logic        sfr_rd_in,      // Read strobe
   input wire logic        irq_enable_in,  // Interrupt enable
   input wire logic        power_down_in,  // Power-down
   input wire logic [7:0]  sfr_rdata_out,  // Read data
   input wire logic        irq_out,        // Request
   input wire logic        wake_out,       // Wake
   input wire logic [15:0] vector_out      // Service address
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   // Control writes may clear the flag, so they excuse a drop
   logic ctl_wr;
   assign ctl_wr = sfr_wr_in && sfr_addr_in == TIC_ADDR_CTL;
   sequence s_cmp_wr; sfr_wr_in && sfr_addr_in == TIC_ADDR_INTERVAL_COMPARE_VALUE; endsequence
   sequence s_cmp_rd; sfr_rd_in && sfr_addr_in == TIC_ADDR_INTERVAL_COMPARE_VALUE; endsequence
   property p_vec; vector_out == (irq_out ? TIC_VECTOR : TIC_NO_VECTOR); endproperty
   a_vec: assert property (p_vec) else $error("vector disagrees with request");
   property p_wake; wake_out |-> irq_out && $past(power_down_in); endproperty
   a_wake: assert property (p_wake) else $error("wake without request");
   property p_wake_pd; power_down_in && irq_enable_in ##1 irq_out |-> wake_out; endproperty
   a_wake_pd: assert property (p_wake_pd) else $error("no wake in power-down");
   property p_en_off; !irq_enable_in |=> !irq_out; endproperty
   a_en_off: assert property (p_en_off) else $error("request while disabled");
   property p_hold; irq_out && irq_enable_in && !ctl_wr && !$past(ctl_wr) |=> irq_out; endproperty
   a_hold: assert property (p_hold) else $error("flag dropped by itself");
   property p_flag_rd;
      sfr_rd_in && sfr_addr_in == TIC_ADDR_CTL && irq_out && !$past(ctl_wr) |=> sfr_rdata_out[TIC_BIT_FLAG];
   endproperty
   a_flag_rd: assert property (p_flag_rd) else $error("flag not read back");
   property p_bit7; sfr_rd_in && sfr_addr_in == TIC_ADDR_CTL |=> !sfr_rdata_out[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("absent bit reads one");
   property p_cmp; s_cmp_wr ##2 s_cmp_rd |=> sfr_rdata_out == $past(sfr_wdata_in, 3); endproperty
   a_cmp: assert property (p_cmp) else $error("compare value lost");
endmodule // tic_properties

// *** bench/tic_core_model.sv ***
// Purpose: Core side: register strobes and crystal source
// Assumes: Device samples the bus on rising clock_in
// Notes:   Crystal sped up so 1/128 s ticks fit the run
`timescale 1ns/10ps
module tic_core_model (
   input  wire logic       clock_in,   // Core clock
   output logic [7:0]      addr_out,   // Address
   output logic [7:0]      wdata_out,  // Write data
   output logic            wr_out,     // Write strobe
   output logic            rd_out,     // Read strobe
   output logic            xtal_out,   // Crystal level
   input  wire logic [7:0] rdata_in    // Read data
);
   // Free-running crystal, eight core cycles a period
   initial begin
      {addr_out, wdata_out, wr_out, rd_out, xtal_out} = '0;
      forever begin
         repeat (4) @(posedge clock_in);
         xtal_out <= ~xtal_out;
      end
   end
   // Single write; data inverted after so nothing lingers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clock_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
   endtask
   // Read; waits for the slow access to land before use
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clock_in);
      rd_out   <= 1'b0;
      @(posedge clock_in);
      d = rdata_in;
   endtask
endmodule // tic_core_model

// *** bench/tic_interval_timer_unit_test.sv ***
// Purpose: Self-checking bench for the interval timer unit
// Assumes: Crystal sped up, one 1/128 s tick per 2048 cycles
// Notes:   Time chain preloaded near wrap to reach carries quickly
`timescale 1ns/10ps
module tic_interval_timer_unit_test;
   import tic_pkg::*;
   localparam logic [7:0] TV [4] = '{8'h7f, 8'h3b, 8'h3b, 8'h17};
   logic        clock_in, srst_in, irq_enable_in, power_down_in, xtal_in;
   logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
   logic        sfr_wr_in, sfr_rd_in, irq_out, wake_out;
   logic [15:0] vector_out;
   int          err_total, cmp_count, cyc, n;
   tic_interval_timer_unit tic_interval_timer_unit_i (.clock_in, .srst_in, .xtal_in, .sfr_addr_in,
      .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .irq_enable_in, .power_down_in, .sfr_rdata_out,
      .irq_out, .wake_out, .vector_out);
   tic_core_model core_i (.clock_in, .addr_out(sfr_addr_in), .wdata_out(sfr_wdata_in),
      .wr_out(sfr_wr_in), .rd_out(sfr_rd_in), .xtal_out(xtal_in), .rdata_in(sfr_rdata_out));
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   // Hang guard, about half again the expected run of 23k cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 36000) begin
         err_total++;
         finish_test;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      core_i.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq_out !== 1'b1 && n < lim) begin
         @(posedge clock_in);
         n++;
      end
   endtask
   // Load the chain while stopped, then read it back
   task automatic preload;
      for (int i = 0; i < 4; i++)
         core_i.wr(TIC_ADDR_FRAC + 8'(i), TV[i]);
      for (int i = 0; i < 4; i++)
         rc(TIC_ADDR_FRAC + 8'(i), TV[i]);
   endtask
   task automatic finish_test;
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {err_total, cmp_count, cyc} = '0;
      {srst_in, irq_enable_in, power_down_in} = 3'b100;
      repeat (5) @(posedge clock_in);
      srst_in <= 1'b0;
      // Reset values, absent bit, unmapped place
      rc(TIC_ADDR_CTL, TIC_RST_CTL);
      rc(TIC_ADDR_INTERVAL_COMPARE_VALUE, TIC_RST_INTERVAL_COMPARE_VALUE);
      core_i.wr(TIC_ADDR_CTL, 8'h80);
      rc(TIC_ADDR_CTL, 8'h00);
      core_i.wr(TIC_ADDR_INTERVAL_COMPARE_VALUE, 8'hff);
      rc(TIC_ADDR_INTERVAL_COMPARE_VALUE, 8'hff);
      rc(8'ha7, 8'h00);
      // Full carry in 24 hour mode, hours base, wake in power-down
      irq_enable_in <= 1'b1;
      power_down_in <= 1'b1;
      preload;
      core_i.wr(TIC_ADDR_INTERVAL_COMPARE_VALUE, 8'h01);
      core_i.wr(TIC_ADDR_CTL, 8'h73);
      wait_irq(3000);
      chk(vector_out, TIC_VECTOR);
      chk({15'h0, wake_out}, 16'h1);
      rc(TIC_ADDR_CTL, 8'h77);
      for (int i = 0; i < 4; i++)
         rc(TIC_ADDR_FRAC + 8'(i), 8'h00);
      core_i.wr(TIC_ADDR_SEC, 8'h05);
      core_i.wr(TIC_ADDR_CTL, 8'h72);
      power_down_in <= 1'b0;
      for (int i = 0; i < 4; i++)
         rc(TIC_ADDR_FRAC + 8'(i), TV[i]);
      chk({15'h0, irq_out}, 16'h0);
      // Hour past 23 in long mode, single shot on one tick
      preload;
      core_i.wr(TIC_ADDR_CTL, 8'h0b);
      wait_irq(3000);
      chk({15'h0, wake_out}, 16'h0);
      rc(TIC_ADDR_CTL, 8'h0d);
      rc(TIC_ADDR_HOUR, 8'h18);
      // Auto reload: next match two ticks after the last
      core_i.wr(TIC_ADDR_INTERVAL_COMPARE_VALUE, 8'h02);
      core_i.wr(TIC_ADDR_CTL, 8'h03);
      // Old request still stands one cycle after the clearing write
      repeat (2) @(posedge clock_in);
      wait_irq(5000);
      core_i.wr(TIC_ADDR_CTL, 8'h03);
      repeat (2) @(posedge clock_in);
      wait_irq(5000);
      chk(16'(n > 4000 && n < 4100), 16'h1);
      // Interval counter off: no match over three ticks
      core_i.wr(TIC_ADDR_INTERVAL_COMPARE_VALUE, 8'h01);
      core_i.wr(TIC_ADDR_CTL, 8'h01);
      repeat (6200) @(posedge clock_in);
      rc(TIC_ADDR_CTL, 8'h01);
      chk({15'h0, irq_out}, 16'h0);
      // Seconds base fires on a fraction wrap, minutes base does not
      core_i.wr(TIC_ADDR_CTL, 8'h00);
      core_i.wr(TIC_ADDR_SEC, 8'h3a);
      core_i.wr(TIC_ADDR_CTL, 8'h13);
      wait_irq(3000);
      rc(TIC_ADDR_CTL, 8'h17);
      core_i.wr(TIC_ADDR_CTL, 8'h00);
      core_i.wr(TIC_ADDR_CTL, 8'h23);
      repeat (2300) @(posedge clock_in);
      rc(TIC_ADDR_SEC, 8'h3b);
      rc(TIC_ADDR_CTL, 8'h23);
      finish_test;
   end
endmodule // tic_interval_timer_unit_test
bind tic_interval_timer_unit tic_properties tic_properties_i (.clock_in, .srst_in, .xtal_in, .sfr_addr_in,
   .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .irq_enable_in, .power_down_in, .sfr_rdata_out,
   .irq_out, .wake_out, .vector_out);
